/* inc/gauge_pkg.sv */
/*
 package for the fuel-gauge power, reset and start-up sequencer:
 timing counts, register map, mode codes, state encodings and state records.
 assumes a 50 MHz clk; all counts derive from it.
*/
package gauge_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SPIKE_NS = 50;
    localparam int FILTER_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam logic [2:0] FILT_LAST = 3'(FILTER_CYCLES - 1);
    localparam int HOLD_NS = 300;
    localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYCLES - 1);
    localparam int WAKE_NS = 2000;
    localparam int WAKE_CYCLES = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] WAKE_LAST = 7'(WAKE_CYCLES - 1);
    localparam int RESET_NS = 1000;
    localparam int RESET_CYCLES = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] RESET_LAST = 7'(RESET_CYCLES - 1);

    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SUPPLY = 2;
    localparam logic [2:0] FILT_RESET = 3'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_INT_FLAGS = 8'h03;
    localparam logic [7:0] REG_INT_MASK = 8'h04;
    localparam logic [7:0] REG_INT_CLR = 8'h05;
    localparam logic [7:0] REG_RUNTIME_CFG = 8'h06;
    localparam logic [7:0] REG_BATT_TEMP = 8'h07;
    localparam logic [7:0] RSV_LO = 8'h10;
    localparam logic [7:0] RSV_HI = 8'h1F;
    localparam logic [7:0] LOCK_LO = 8'h20;
    localparam logic [7:0] LOCK_HI = 8'h3F;
    localparam logic [7:0] REG_LAST = 8'h3F;

    localparam int MODE_START_BIT = 2;
    localparam logic [1:0] PWR_KEEP = 2'h0;
    localparam logic [1:0] PWR_ACTIVE = 2'h1;
    localparam logic [1:0] PWR_HIBERNATE = 2'h2;
    localparam logic [1:0] PWR_SHUTDOWN = 2'h3;
    localparam int INT_RDY_BIT = 0;
    localparam int STAT_GAUGE_BIT = 0;
    localparam int STAT_MODE_LSB = 1;

    typedef enum logic [3:0] {
        P_SHUTDOWN = 4'b0001,
        P_WAKING = 4'b0010,
        P_ACTIVE = 4'b0100,
        P_HIBERNATE = 4'b1000
    } pwr_e;

    typedef enum logic [9:0] {
        B_IDLE = 10'b00_0000_0001,
        B_ADDR = 10'b00_0000_0010,
        B_ADDR_ACK = 10'b00_0000_0100,
        B_REG = 10'b00_0000_1000,
        B_REG_ACK = 10'b00_0001_0000,
        B_WDATA = 10'b00_0010_0000,
        B_WDATA_ACK = 10'b00_0100_0000,
        B_RDATA = 10'b00_1000_0000,
        B_RDATA_ACK = 10'b01_0000_0000,
        B_IGNORE = 10'b10_0000_0000
    } bus_e;

    typedef struct packed {
        logic afeOn;
        logic cpuClk;
        logic gauging;
        logic [1:0] mode;
    } pwr_ctl_s;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic [2:0] clean;
        logic [2:0][2:0] cnt;
    } filt_s;

    typedef struct packed {
        pwr_e pwr;
        logic [6:0] wakeCnt;
        bus_e bus;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic sclQ;
        logic sdaQ;
        logic pendValid;
        logic pendOeN;
        logic [3:0] holdCnt;
        logic sdaOeN;
        logic intN;
        pwr_ctl_s ctl;
        logic [63:0][7:0] mem;
    } seq_s;

    localparam seq_s SEQ_RESET = '{pwr: P_SHUTDOWN, bus: B_IDLE, sclQ: 1'b1, sdaQ: 1'b1,
        pendOeN: 1'b1, sdaOeN: 1'b1, intN: 1'b1,
        ctl: '{afeOn: 1'b0, cpuClk: 1'b0, gauging: 1'b0, mode: PWR_SHUTDOWN}, default: '0};
endpackage : gauge_pkg

/* design/pin_glitch_filter.sv */
/*
 two-flop synchroniser and spike filter for the serial clock, serial data
 and supply-good pins. assumes asynchronous pins and the 50 MHz clk.
*/
`timescale 1ns/1ns
module pin_glitch_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] rawIn,
    output logic [2:0] cleanOut
);
    gauge_pkg::filt_s st;
    gauge_pkg::filt_s nxt;

    always_comb begin
        nxt = st;
        nxt.meta = rawIn;
        nxt.sync = st.meta;
        for (int i = 0; i < 3; i++) begin
            // a level must hold past the spike width before it is taken
            if (st.sync[i] == st.clean[i]) begin
                nxt.cnt[i] = '0;
            end else if (st.cnt[i] == gauge_pkg::FILT_LAST) begin
                nxt.clean[i] = st.sync[i];
                nxt.cnt[i] = '0;
            end else begin
                nxt.cnt[i] = st.cnt[i] + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{meta: gauge_pkg::FILT_RESET, sync: gauge_pkg::FILT_RESET,
                clean: gauge_pkg::FILT_RESET, cnt: '0};
        end else begin
            st <= nxt;
        end
    end

    assign cleanOut = st.clean;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_scl_spike;
        $changed(st.clean[gauge_pkg::PIN_SCL]) |-> $past(st.cnt[gauge_pkg::PIN_SCL]) == gauge_pkg::FILT_LAST;
    endproperty
    a_scl_spike: assert property (p_scl_spike) else $error("scl changed before filter time");

    property p_sda_spike;
        (st.sync[gauge_pkg::PIN_SDA] != st.clean[gauge_pkg::PIN_SDA]
            && st.cnt[gauge_pkg::PIN_SDA] != gauge_pkg::FILT_LAST) ##1
        (st.sync[gauge_pkg::PIN_SDA] == st.clean[gauge_pkg::PIN_SDA]) |-> $stable(st.clean[gauge_pkg::PIN_SDA]);
    endproperty
    a_sda_spike: assert property (p_sda_spike) else $error("sda short pulse passed filter");
endmodule : pin_glitch_filter

/* design/gauge_power_mode_sequencer.sv */
/*
 power-mode, reset and start-up sequencer of the fuel gauge, with its
 i2c target port and register file. assumes open-drain scl/sda with
 external pull-ups, a 50 MHz clk and scl no faster than 400 kHz.
*/
`timescale 1ns/1ns
module gauge_power_mode_sequencer #(
    parameter logic [6:0] TARGET_ADDR = 7'h55
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic supplyOk,
    output logic intN,
    output gauge_pkg::pwr_ctl_s powerCtl
);
    gauge_pkg::seq_s st;
    gauge_pkg::seq_s nxt;
    logic [2:0] pinClean;
    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic wrByte;
    logic rdySet;
    logic lockHit;
    logic rsvHit;
    logic [7:0] rdByte;
    logic [5:0] idx;

    pin_glitch_filter uFilter (
        .clk(clk),
        .rst_n(rst_n),
        .rawIn({supplyOk, sdaIn, sclIn}),
        .cleanOut(pinClean)
    );

    always_comb begin
        nxt = st;
        scl = pinClean[gauge_pkg::PIN_SCL];
        sda = pinClean[gauge_pkg::PIN_SDA];
        // edges seen by sampling the filtered link clock
        sclRise = scl & ~st.sclQ;
        sclFall = ~scl & st.sclQ;
        startCond = scl & st.sclQ & st.sdaQ & ~sda;
        stopCond = scl & st.sclQ & ~st.sdaQ & sda;
        nxt.sclQ = scl;
        nxt.sdaQ = sda;
        wrByte = 1'b0;
        idx = st.ptr[5:0];
        lockHit = st.ctl.gauging && st.ptr >= gauge_pkg::LOCK_LO && st.ptr <= gauge_pkg::LOCK_HI;
        rsvHit = st.ctl.gauging && st.ptr >= gauge_pkg::RSV_LO && st.ptr <= gauge_pkg::RSV_HI;
        rdByte = (st.ptr > gauge_pkg::REG_LAST) ? 8'h00 : st.mem[idx];
        if (st.ptr == gauge_pkg::REG_STATUS) begin
            rdByte = 8'h00;
            rdByte[gauge_pkg::STAT_GAUGE_BIT] = st.ctl.gauging;
            rdByte[gauge_pkg::STAT_MODE_LSB +: 2] = st.ctl.mode;
        end

        // wake or reset sequence timing
        rdySet = 1'b0;
        unique case (st.pwr)
            gauge_pkg::P_WAKING: begin
                if (st.wakeCnt == '0) begin
                    nxt.pwr = gauge_pkg::P_ACTIVE;
                    rdySet = 1'b1;
                end else begin
                    nxt.wakeCnt = st.wakeCnt - 7'h01;
                end
            end
            gauge_pkg::P_SHUTDOWN, gauge_pkg::P_ACTIVE, gauge_pkg::P_HIBERNATE: ;
        endcase

        if (startCond) begin
            nxt.bus = gauge_pkg::B_ADDR;
            nxt.bitCnt = '0;
            nxt.pendValid = 1'b0;
            nxt.sdaOeN = 1'b1;
        end else if (stopCond) begin
            nxt.bus = gauge_pkg::B_IDLE;
            nxt.pendValid = 1'b0;
            nxt.sdaOeN = 1'b1;
        end else if (sclRise) begin
            if (st.bus inside {gauge_pkg::B_ADDR, gauge_pkg::B_REG, gauge_pkg::B_WDATA}) begin
                nxt.shift = {st.shift[6:0], sda};
                nxt.bitCnt = st.bitCnt + 4'h1;
            end else if (st.bus == gauge_pkg::B_RDATA) begin
                nxt.bitCnt = st.bitCnt + 4'h1;
            end else if (st.bus == gauge_pkg::B_RDATA_ACK) begin
                nxt.nack = sda;
            end
        end else if (sclFall) begin
            // sda changes only after the hold delay past this fall
            nxt.pendValid = 1'b1;
            nxt.holdCnt = gauge_pkg::HOLD_LAST;
            nxt.pendOeN = 1'b1;
            unique case (st.bus)
                gauge_pkg::B_ADDR: begin
                    if (st.bitCnt == gauge_pkg::BITS_PER_BYTE) begin
                        if (st.shift[7:1] != TARGET_ADDR) begin
                            nxt.bus = gauge_pkg::B_IGNORE;
                        end else if (st.pwr == gauge_pkg::P_SHUTDOWN) begin
                            // no acknowledge; wake only with supply present
                            nxt.bus = gauge_pkg::B_IGNORE;
                            if (pinClean[gauge_pkg::PIN_SUPPLY]) begin
                                nxt.pwr = gauge_pkg::P_WAKING;
                                nxt.wakeCnt = gauge_pkg::WAKE_LAST;
                            end
                        end else if (st.pwr == gauge_pkg::P_WAKING) begin
                            nxt.bus = gauge_pkg::B_IGNORE;
                        end else begin
                            // active and hibernate both answer
                            nxt.bus = gauge_pkg::B_ADDR_ACK;
                            nxt.rw = st.shift[0];
                            nxt.pendOeN = 1'b0;
                        end
                    end
                end
                gauge_pkg::B_ADDR_ACK: begin
                    nxt.bitCnt = '0;
                    if (st.rw) begin
                        nxt.shift = rdByte;
                        nxt.pendOeN = rdByte[7];
                        nxt.bus = gauge_pkg::B_RDATA;
                    end else begin
                        nxt.bus = gauge_pkg::B_REG;
                    end
                end
                gauge_pkg::B_REG: begin
                    if (st.bitCnt == gauge_pkg::BITS_PER_BYTE) begin
                        nxt.ptr = st.shift;
                        nxt.pendOeN = 1'b0;
                        nxt.bus = gauge_pkg::B_REG_ACK;
                    end
                end
                gauge_pkg::B_REG_ACK, gauge_pkg::B_WDATA_ACK: begin
                    nxt.bus = gauge_pkg::B_WDATA;
                    nxt.bitCnt = '0;
                end
                gauge_pkg::B_WDATA: begin
                    if (st.bitCnt == gauge_pkg::BITS_PER_BYTE) begin
                        wrByte = 1'b1;
                        nxt.ptr = st.ptr + 8'h01;
                        nxt.pendOeN = 1'b0;
                        nxt.bus = gauge_pkg::B_WDATA_ACK;
                    end
                end
                gauge_pkg::B_RDATA: begin
                    if (st.bitCnt == gauge_pkg::BITS_PER_BYTE) begin
                        nxt.ptr = st.ptr + 8'h01;
                        nxt.bus = gauge_pkg::B_RDATA_ACK;
                    end else begin
                        nxt.shift = {st.shift[6:0], 1'b0};
                        nxt.pendOeN = st.shift[6];
                    end
                end
                gauge_pkg::B_RDATA_ACK: begin
                    if (st.nack) begin
                        nxt.bus = gauge_pkg::B_IGNORE;
                    end else begin
                        nxt.shift = rdByte;
                        nxt.pendOeN = rdByte[7];
                        nxt.bitCnt = '0;
                        nxt.bus = gauge_pkg::B_RDATA;
                    end
                end
                gauge_pkg::B_IDLE, gauge_pkg::B_IGNORE: ;
            endcase
        end else if (st.pendValid) begin
            if (st.holdCnt == '0) begin
                nxt.sdaOeN = st.pendOeN;
                nxt.pendValid = 1'b0;
            end else begin
                nxt.holdCnt = st.holdCnt - 4'h1;
            end
        end

        if (wrByte) begin
            if (st.ptr == gauge_pkg::REG_RESET) begin
                nxt.mem = '0;
                nxt.pwr = gauge_pkg::P_WAKING;
                nxt.wakeCnt = gauge_pkg::RESET_LAST;
            end else if (st.ptr == gauge_pkg::REG_MODE) begin
                nxt.mem[idx] = st.shift;
                unique case (st.shift[1:0])
                    gauge_pkg::PWR_SHUTDOWN: begin
                        nxt.mem = '0;
                        nxt.pwr = gauge_pkg::P_SHUTDOWN;
                        // device is off: no ack, rest of the transfer dropped
                        nxt.pendOeN = 1'b1;
                        nxt.bus = gauge_pkg::B_IGNORE;
                    end
                    gauge_pkg::PWR_HIBERNATE: nxt.pwr = gauge_pkg::P_HIBERNATE;
                    gauge_pkg::PWR_ACTIVE: nxt.pwr = gauge_pkg::P_ACTIVE;
                    gauge_pkg::PWR_KEEP: ;
                endcase
            end else if (st.ptr == gauge_pkg::REG_INT_CLR) begin
                nxt.mem[gauge_pkg::REG_INT_FLAGS[5:0]] = st.mem[gauge_pkg::REG_INT_FLAGS[5:0]] & ~st.shift;
            end else if (st.ptr == gauge_pkg::REG_STATUS || st.ptr == gauge_pkg::REG_INT_FLAGS) begin
                nxt.mem = st.mem;
            end else if (st.ptr > gauge_pkg::REG_LAST || lockHit || rsvHit) begin
                nxt.mem = st.mem;
            end else begin
                nxt.mem[idx] = st.shift;
            end
        end

        // hardware set applied last so it beats a clear in the same cycle
        if (rdySet && nxt.pwr == gauge_pkg::P_ACTIVE) begin
            nxt.mem[gauge_pkg::REG_INT_FLAGS[5:0]][gauge_pkg::INT_RDY_BIT] = 1'b1;
        end

        nxt.ctl.afeOn = nxt.pwr == gauge_pkg::P_ACTIVE;
        nxt.ctl.cpuClk = nxt.pwr inside {gauge_pkg::P_ACTIVE, gauge_pkg::P_WAKING};
        nxt.ctl.gauging = nxt.pwr == gauge_pkg::P_ACTIVE
            && nxt.mem[gauge_pkg::REG_MODE[5:0]][gauge_pkg::MODE_START_BIT];
        unique case (nxt.pwr)
            gauge_pkg::P_ACTIVE: nxt.ctl.mode = gauge_pkg::PWR_ACTIVE;
            gauge_pkg::P_HIBERNATE: nxt.ctl.mode = gauge_pkg::PWR_HIBERNATE;
            gauge_pkg::P_SHUTDOWN, gauge_pkg::P_WAKING: nxt.ctl.mode = gauge_pkg::PWR_SHUTDOWN;
        endcase
        nxt.intN = ~|(nxt.mem[gauge_pkg::REG_INT_FLAGS[5:0]] & ~nxt.mem[gauge_pkg::REG_INT_MASK[5:0]]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= gauge_pkg::SEQ_RESET;
        end else begin
            st <= nxt;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOeN = st.sdaOeN;
    assign intN = st.intN;
    assign powerCtl = st.ctl;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_soft_reset;
        wrByte && st.ptr == gauge_pkg::REG_RESET |=>
            st.pwr == gauge_pkg::P_WAKING && st.mem[gauge_pkg::REG_INT_MASK[5:0]] == 8'h00 && !powerCtl.gauging;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear");

    property p_ready_after_reset;
        st.pwr == gauge_pkg::P_WAKING && st.wakeCnt == 7'h00 |=>
            st.pwr == gauge_pkg::P_ACTIVE && st.mem[gauge_pkg::REG_INT_FLAGS[5:0]][gauge_pkg::INT_RDY_BIT];
    endproperty
    a_ready_after_reset: assert property (p_ready_after_reset) else $error("ready flag missing");

    property p_mode_shutdown;
        wrByte && st.ptr == gauge_pkg::REG_MODE && st.shift[1:0] == gauge_pkg::PWR_SHUTDOWN |=>
            st.pwr == gauge_pkg::P_SHUTDOWN && st.mem == '0;
    endproperty
    a_mode_shutdown: assert property (p_mode_shutdown) else $error("shutdown request did not reset");

    property p_shutdown_quiet;
        st.pwr == gauge_pkg::P_SHUTDOWN |-> !powerCtl.afeOn && !powerCtl.cpuClk && sdaOeN;
    endproperty
    a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("shutdown not quiet");

    property p_wake;
        st.pwr == gauge_pkg::P_SHUTDOWN ##1 st.pwr == gauge_pkg::P_WAKING |->
            ##[99:101] (st.pwr == gauge_pkg::P_ACTIVE && !intN);
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not raise interrupt in time");

    property p_start;
        wrByte && st.ptr == gauge_pkg::REG_MODE && st.pwr == gauge_pkg::P_ACTIVE
            && st.shift[gauge_pkg::MODE_START_BIT] && st.shift[1:0] != gauge_pkg::PWR_SHUTDOWN
            && st.shift[1:0] != gauge_pkg::PWR_HIBERNATE |=> powerCtl.gauging;
    endproperty
    a_start: assert property (p_start) else $error("start bit did not start gauging");

    property p_status;
        st.ptr == gauge_pkg::REG_STATUS |-> rdByte[gauge_pkg::STAT_GAUGE_BIT] == powerCtl.gauging;
    endproperty
    a_status: assert property (p_status) else $error("status does not show gauging");

    property p_lock;
        wrByte && lockHit |=> st.mem == $past(st.mem);
    endproperty
    a_lock: assert property (p_lock) else $error("locked register written");

    property p_reserved;
        wrByte && rsvHit |=> st.mem == $past(st.mem);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved register written");

    property p_active;
        st.pwr == gauge_pkg::P_ACTIVE |-> powerCtl.afeOn && powerCtl.cpuClk
            && powerCtl.mode == gauge_pkg::PWR_ACTIVE;
    endproperty
    a_active: assert property (p_active) else $error("active mode not powered");

    property p_hibernate;
        st.pwr == gauge_pkg::P_HIBERNATE |-> !powerCtl.afeOn && !powerCtl.cpuClk && !powerCtl.gauging;
    endproperty
    a_hibernate: assert property (p_hibernate) else $error("hibernate left front end on");

    property p_shutdown_nack;
        st.bus == gauge_pkg::B_ADDR && sclFall && st.bitCnt == gauge_pkg::BITS_PER_BYTE
            && st.pwr == gauge_pkg::P_SHUTDOWN |=> st.bus == gauge_pkg::B_IGNORE && st.pendOeN;
    endproperty
    a_shutdown_nack: assert property (p_shutdown_nack) else $error("shutdown acknowledged address");

    property p_hold;
        sclFall && !startCond && !stopCond |=> $stable(sdaOeN)[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("sda changed inside hold time");

    property p_interrupt;
        wrByte && st.ptr == gauge_pkg::REG_INT_CLR && !rdySet
            && (st.mem[gauge_pkg::REG_INT_FLAGS[5:0]] & ~st.shift) == 8'h00 |=> intN;
    endproperty
    a_interrupt: assert property (p_interrupt) else $error("interrupt level wrong");

    property p_int_level;
        (|(st.mem[gauge_pkg::REG_INT_FLAGS[5:0]] & ~st.mem[gauge_pkg::REG_INT_MASK[5:0]])) == !intN;
    endproperty
    a_int_level: assert property (p_int_level) else $error("interrupt not tied to flags");

    c_wake: cover property (st.pwr == gauge_pkg::P_WAKING ##1 st.pwr == gauge_pkg::P_ACTIVE);
    c_soft_reset: cover property (wrByte && st.ptr == gauge_pkg::REG_RESET);
    c_gauging: cover property ($rose(powerCtl.gauging));
    c_hibernate: cover property ($rose(st.pwr == gauge_pkg::P_HIBERNATE));
    c_read: cover property (st.bus == gauge_pkg::B_RDATA_ACK && sclFall);
endmodule : gauge_power_mode_sequencer

/* sim/i2c_host_model.sv */
/*
 i2c host model: open-drain scl/sda, byte-level transfer tasks.
 assumes pull-ups on both lines and an active-low sda enable from the device.
*/
`timescale 1ns/1ns
module i2c_host_model #(
    parameter logic [6:0] ADDR = 7'h55
) (
    output logic scl,
    output logic sda,
    input wire logic devOeN
);
    localparam int Q = 650; // quarter bit, 385 kHz
    logic pullScl = 1'b0;
    logic pullSda = 1'b0;
    localparam int SPIKE = 40; // below the 50 ns filter limit
    logic spikeOn = 1'b0;
    assign scl = ~pullScl;
    assign sda = ~(pullSda | ~devOeN);
    task automatic bitx(input logic b, output logic r);
        pullSda = ~b;
        #Q pullScl = 1'b0;
        #Q r = sda;
        if (spikeOn) begin
            pullScl = 1'b1;
            #SPIKE pullScl = 1'b0;
        end
        #Q pullScl = 1'b1;
        #Q;
    endtask : bitx
    task automatic start();
        pullSda = 1'b0;
        #Q pullScl = 1'b0;
        #Q pullSda = 1'b1;
        #Q pullScl = 1'b1;
        #Q;
    endtask : start
    task automatic stop();
        pullSda = 1'b1;
        #Q pullScl = 1'b0;
        #Q pullSda = 1'b0;
        #(3 * Q);
    endtask : stop
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, r);
        ack = ~r;
    endtask : xbyte
    // addressing wakes, mode and start bits written here
    task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ack);
        logic [7:0] q;
        logic k;
        start();
        xbyte({ADDR, 1'b0}, q, ack);
        if (ack) begin
            xbyte(r, q, k);
            xbyte(d, q, k);
        end
        stop();
    endtask : wr
    task automatic rd(input logic [7:0] r, output logic [7:0] v, output logic ack);
        logic k;
        start();
        xbyte({ADDR, 1'b0}, v, ack);
        if (ack) begin
            xbyte(r, v, k);
            start();
            xbyte({ADDR, 1'b1}, v, k);
            xbyte(8'hFF, v, k);
        end
        stop();
    endtask : rd
endmodule : i2c_host_model

/* sim/tb_top.sv */
/*
 testbench of the gauge sequencer: wake, registers, gauging, modes, reset.
 assumes the i2c host model and the default target address.
*/
`timescale 1ns/1ns
module tb_top;
    typedef struct {logic [7:0] r; logic [7:0] d; logic [7:0] e;} row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supplyOk = 1'b0;
    logic scl, sda, sdaOut, sdaOeN, intN, a;
    logic [7:0] q;
    gauge_pkg::pwr_ctl_s powerCtl;
    int failures = 0;
    int tests_run = 0;
    row_s rows[3] = '{'{8'h20, 8'hA5, 8'hA5}, '{8'h05, 8'h01, 8'h00}, '{8'h04, 8'h01, 8'h01}};
    always #10 clk = ~clk;
    gauge_power_mode_sequencer uut (.clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .supplyOk(supplyOk), .intN(intN), .powerCtl(powerCtl));
    i2c_host_model host (.scl(scl), .sda(sda), .devOeN(sdaOeN));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #2_000_000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        supplyOk <= 1'b1;
        repeat (10) @(posedge clk);
        chk("powerCtl", 8'(powerCtl), 8'h03);
        chk("sdaOut", 8'(sdaOut), 8'h00);
        host.wr(8'h03, 8'h00, a);
        chk("wake ack", 8'(a), 8'h00);
        repeat (120) @(posedge clk);
        chk("powerCtl", 8'(powerCtl), 8'h19);
        chk("intN", 8'(intN), 8'h00);
        foreach (rows[i]) begin
            host.wr(rows[i].r, rows[i].d, a);
            chk("row ack", 8'(a), 8'h01);
            host.rd(rows[i].r, q, a);
            chk("row", q, rows[i].e);
        end
        chk("intN", 8'(intN), 8'h01);
        host.wr(8'h01, 8'h05, a);
        chk("powerCtl", 8'(powerCtl), 8'h1D);
        host.rd(8'h02, q, a);
        chk("status", q, 8'h03);
        host.wr(8'h20, 8'h11, a);
        host.rd(8'h20, q, a);
        chk("locked", q, 8'hA5);
        host.wr(8'h10, 8'h11, a);
        host.rd(8'h10, q, a);
        chk("reserved", q, 8'h00);
        host.wr(8'h01, 8'h06, a);
        chk("powerCtl", 8'(powerCtl), 8'h02);
        host.wr(8'h20, 8'h11, a);
        host.rd(8'h20, q, a);
        chk("unlocked", q, 8'h11);
        host.wr(8'h01, 8'h03, a);
        chk("powerCtl", 8'(powerCtl), 8'h03);
        host.rd(8'h20, q, a);
        chk("read ack", 8'(a), 8'h00);
        repeat (120) @(posedge clk);
        host.rd(8'h20, q, a);
        chk("lost", q, 8'h00);
        host.wr(8'h20, 8'h11, a);
        host.wr(8'h00, 8'h00, a);
        repeat (70) @(posedge clk);
        chk("intN", 8'(intN), 8'h00);
        host.rd(8'h20, q, a);
        chk("defaults", q, 8'h00);
        host.spikeOn = 1'b1;
        host.wr(8'h01, 8'h04, a);
        host.spikeOn = 1'b0;
        chk("spike ack", 8'(a), 8'h01);
        chk("powerCtl", 8'(powerCtl), 8'h1D);
        rst_n <= 1'b0;
        supplyOk <= 1'b0;
        repeat (2) @(posedge clk);
        chk("intN", 8'(intN), 8'h01);
        rst_n <= 1'b1;
        host.rd(8'h01, q, a);
        chk("no supply ack", 8'(a), 8'h00);
        repeat (120) @(posedge clk);
        chk("powerCtl", 8'(powerCtl), 8'h03);
        wrap_up();
    end
endmodule : tb_top
